// [hw/branch_consts.svh]
`ifndef BRANCH_CONSTS_SVH
`define BRANCH_CONSTS_SVH

// ==========================================
// Opcode match masks and values
`define OP_COND_REL_MASK  16'hfc00
`define OP_COND_REL_VAL   16'h3000
`define OP_CALL_ABS_MASK  16'hfff7
`define OP_CALL_ABS_VAL   16'h39b5
`define OP_CALL_REL_MASK  16'hffe0
`define OP_CALL_REL_VAL   16'h2f20
`define OP_TC_LOAD_MASK   16'he007
`define OP_TC_LOAD_VAL    16'ha004

// ==========================================
// Field positions
`define F_DEST_LSB     0
`define F_DEST_MSB     4
`define F_SEL_LSB      5
`define F_SEL_MSB      8
`define F_POL          9
`define F_JREG         3
`define F_SRC_LSB      3
`define F_SRC_MSB      5
`define F_TC_LSB       6
`define F_TC_MSB       7
`define F_SC_TWO_LSB   8
`define F_SC_TWO_MSB   9
`define F_SC_ONE_LSB   10
`define F_SC_ONE_MSB   11
`define F_CLR          12

// ==========================================
// Shortcut actions
`define SC_KEEP        2'h0
`define SC_OFF         2'h1
`define SC_ON          2'h2
`define SC_TOGGLE      2'h3

// ==========================================
// Status register addresses
`define STATUS_A_LO    12'h101
`define STATUS_A_HI    12'h102
`define STATUS_B_LO    12'h121
`define STATUS_B_HI    12'h122

// ==========================================
// Reset values
`define PC_RESET       16'h0000
`define AUX_RESET      16'h0000

`endif

// [hw/branch_pkg.sv]
package branch_pkg;

    // ==========================================
    // Types
    typedef enum logic [2:0] {
        KIND_COND_REL,
        KIND_CALL_ABS,
        KIND_CALL_REL,
        KIND_TC_LOAD,
        KIND_FOREIGN
    } insn_kind_t;

    // Signed 5-bit offset added to the jump's own location
    function automatic logic [15:0] rel_target(input logic [15:0] here, input logic [4:0] dest);
        logic [15:0] ext;
        ext = {{11{dest[4]}}, dest};
        return 16'(here + ext);
    endfunction : rel_target

endpackage : branch_pkg

// [hw/branch_if.sv]
interface branch_if #(parameter int PC_W = 10);
    logic [PC_W-1:0] here_pc;
    logic [4:0]      offset;
    logic [15:0]     status;
    logic [3:0]      bit_sel;
    logic            pol;
    logic [PC_W-1:0] target;
    logic            cond_true;

    modport unit (input here_pc, offset, status, bit_sel, pol, output target, cond_true);
    modport core (output here_pc, offset, status, bit_sel, pol, input target, cond_true);
endinterface : branch_if

// [hw/terminal_count_mem.sv]
module terminal_count_mem #(
    parameter int W     = 16,
    parameter int DEPTH = 4,
    parameter int AW    = 2
) (
    input  wire logic          clk_in,
    input  wire logic          sys_rst_in,
    input  wire logic          wr_en_in,
    input  wire logic [AW-1:0] wr_addr_in,
    input  wire logic [W-1:0]  wr_data_in,
    input  wire logic [AW-1:0] rd_addr_in,
    output logic      [W-1:0]  rd_data_out
);
    logic [W-1:0] mem_r [DEPTH];
    logic [W-1:0] mem_nxt [DEPTH];
    logic [W-1:0] rd_nxt;

    if (DEPTH > (1 << AW))
    begin : g_chk
        $error("terminal_count_mem: depth exceeds address range");
    end

    always_comb
    begin
        mem_nxt = mem_r;
        if (wr_en_in)
        begin
            mem_nxt[wr_addr_in] = wr_data_in;
        end
        rd_nxt = mem_r[rd_addr_in];
    end

    // Read data registered, so a write shows one cycle later
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            for (int i = 0; i < DEPTH; i++)
            begin
                mem_r[i] <= '0;
            end
            rd_data_out <= '0;
        end
        else
        begin
            mem_r       <= mem_nxt;
            rd_data_out <= rd_nxt;
        end
    end
endmodule : terminal_count_mem

// [hw/branch_target_unit.sv]
module branch_target_unit
    import branch_pkg::*;
#(
    parameter int PC_W = 10
) (
    branch_if.unit br
);
    always_comb
    begin
        br.target    = PC_W'(rel_target(16'(br.here_pc), br.offset));
        br.cond_true = (br.status[br.bit_sel] == br.pol);
    end
endmodule : branch_target_unit

// [hw/microcore_branch_counter_load.sv]
`include "branch_consts.svh"

module microcore_branch_counter_load
    import branch_pkg::*;
#(
    parameter int PC_W   = 10,
    parameter int DATA_W = 16,
    parameter int OUT_W  = 12
) (
    input  wire logic                clk_in,
    input  wire logic                sys_rst_in,
    input  wire logic                insn_valid_in,
    input  wire logic [15:0]         insn_word_in,
    input  wire logic [11:0]         status_addr_in,
    input  wire logic [31:0]         core_control_status_a_in,
    input  wire logic [31:0]         core_control_status_b_in,
    input  wire logic [PC_W-1:0]     jump_reg_one_in,
    input  wire logic [PC_W-1:0]     jump_reg_two_in,
    input  wire logic [8*DATA_W-1:0] arith_regs_in,
    input  wire logic [OUT_W-1:0]    first_output_shortcut_in,
    input  wire logic [OUT_W-1:0]    second_output_shortcut_in,
    input  wire logic [1:0]          tc_rd_sel_in,
    output logic      [PC_W-1:0]     micro_program_counter_out,
    output logic      [PC_W-1:0]     return_address_out,
    output logic      [3:0]          count_clear_out,
    output logic      [OUT_W-1:0]    drive_enable_out,
    output logic                     foreign_insn_out,
    output logic      [DATA_W-1:0]   tc_rd_data_out
);
    // ==========================================
    // Elaboration checks
    if (PC_W < 5 || PC_W > 16)
    begin : g_chk_pc
        $error("microcore_branch_counter_load: PC_W must be 5 to 16");
    end
    if (DATA_W < 1 || OUT_W < 1)
    begin : g_chk_w
        $error("microcore_branch_counter_load: widths must be positive");
    end

    // ==========================================
    // Declarations
    logic [PC_W-1:0]   pc_r;
    logic [PC_W-1:0]   pc_nxt;
    logic [PC_W-1:0]   aux_r;
    logic [PC_W-1:0]   aux_nxt;
    logic [3:0]        clr_r;
    logic [3:0]        clr_nxt;
    logic [OUT_W-1:0]  drv_r;
    logic [OUT_W-1:0]  drv_nxt;
    logic              foreign_r;
    logic              foreign_nxt;
    insn_kind_t        kind;
    logic [PC_W-1:0]   pc_inc;
    logic              tc_we;
    logic [1:0]        tc_idx;
    logic [2:0]        src_idx;
    logic [DATA_W-1:0] src_val;
    logic [1:0]        sc_one_code;
    logic [1:0]        sc_two_code;

    branch_if #(.PC_W(PC_W)) br ();

    // ==========================================
    // Functions
    function automatic insn_kind_t decode(input logic [15:0] w);
        if ((w & `OP_COND_REL_MASK) == `OP_COND_REL_VAL)
            return KIND_COND_REL;
        else if ((w & `OP_CALL_ABS_MASK) == `OP_CALL_ABS_VAL)
            return KIND_CALL_ABS;
        else if ((w & `OP_CALL_REL_MASK) == `OP_CALL_REL_VAL)
            return KIND_CALL_REL;
        else if ((w & `OP_TC_LOAD_MASK) == `OP_TC_LOAD_VAL)
            return KIND_TC_LOAD;
        else
            return KIND_FOREIGN;
    endfunction : decode

    // Unmapped address reads as zero, so no bit can be spuriously set
    function automatic logic [15:0] status_word(input logic [11:0] addr, input logic [31:0] a,
                                                input logic [31:0] b);
        unique case (addr)
            `STATUS_A_LO: return a[15:0];
            `STATUS_A_HI: return a[31:16];
            `STATUS_B_LO: return b[15:0];
            `STATUS_B_HI: return b[31:16];
            default:      return 16'h0000;
        endcase
    endfunction : status_word

    function automatic logic [OUT_W-1:0] apply_sc(input logic [OUT_W-1:0] cur,
                                                  input logic [OUT_W-1:0] mask,
                                                  input logic [1:0]       code);
        unique case (code)
            `SC_KEEP:   return cur;
            `SC_OFF:    return cur & ~mask;
            `SC_ON:     return cur | mask;
            `SC_TOGGLE: return cur ^ mask;
        endcase
    endfunction : apply_sc

    // ==========================================
    // Field extraction
    always_comb
    begin
        kind       = decode(insn_word_in);
        pc_inc     = PC_W'(pc_r + 1'b1);
        tc_idx     = insn_word_in[`F_TC_MSB:`F_TC_LSB];
        src_idx    = insn_word_in[`F_SRC_MSB:`F_SRC_LSB];
        src_val    = arith_regs_in[src_idx*DATA_W +: DATA_W];
        sc_one_code = insn_word_in[`F_SC_ONE_MSB:`F_SC_ONE_LSB];
        sc_two_code = insn_word_in[`F_SC_TWO_MSB:`F_SC_TWO_LSB];
        br.here_pc = pc_r;
        br.offset  = insn_word_in[`F_DEST_MSB:`F_DEST_LSB];
        br.status  = status_word(status_addr_in, core_control_status_a_in,
                                 core_control_status_b_in);
        br.bit_sel = insn_word_in[`F_SEL_MSB:`F_SEL_LSB];
        br.pol     = insn_word_in[`F_POL];
    end

    branch_target_unit #(.PC_W(PC_W)) target_unit (
        .br (br)
    );

    // ==========================================
    // Execution next state
    always_comb
    begin
        pc_nxt      = pc_r;
        aux_nxt     = aux_r;
        clr_nxt     = 4'h0;
        drv_nxt     = drv_r;
        foreign_nxt = 1'b0;
        tc_we       = 1'b0;
        if (insn_valid_in)
        begin
            unique case (kind)
                KIND_COND_REL:
                begin
                    pc_nxt = br.cond_true ? br.target : pc_inc;
                end
                KIND_CALL_ABS:
                begin
                    pc_nxt  = insn_word_in[`F_JREG] ? jump_reg_two_in : jump_reg_one_in;
                    aux_nxt = pc_r;
                end
                KIND_CALL_REL:
                begin
                    pc_nxt  = br.target;
                    aux_nxt = pc_r;
                end
                KIND_TC_LOAD:
                begin
                    pc_nxt = pc_inc;
                    tc_we  = 1'b1;
                    if (insn_word_in[`F_CLR])
                    begin
                        clr_nxt = 4'(1 << tc_idx);
                    end
                    // First shortcut applies before the second on shared outputs
                    drv_nxt = apply_sc(apply_sc(drv_r, first_output_shortcut_in, sc_one_code),
                                       second_output_shortcut_in, sc_two_code);
                end
                KIND_FOREIGN:
                begin
                    pc_nxt      = pc_inc;
                    foreign_nxt = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            pc_r      <= PC_W'(`PC_RESET);
            aux_r     <= PC_W'(`AUX_RESET);
            clr_r     <= 4'h0;
            drv_r     <= '0;
            foreign_r <= 1'b0;
        end
        else
        begin
            pc_r      <= pc_nxt;
            aux_r     <= aux_nxt;
            clr_r     <= clr_nxt;
            drv_r     <= drv_nxt;
            foreign_r <= foreign_nxt;
        end
    end

    // ==========================================
    // Terminal count registers a to d
    terminal_count_mem #(.W(DATA_W), .DEPTH(4), .AW(2)) terminal_count_bank (
        .clk_in      (clk_in),
        .sys_rst_in  (sys_rst_in),
        .wr_en_in    (tc_we),
        .wr_addr_in  (tc_idx),
        .wr_data_in  (src_val),
        .rd_addr_in  (tc_rd_sel_in),
        .rd_data_out (tc_rd_data_out)
    );

    // ==========================================
    // Outputs
    always_comb
    begin
        micro_program_counter_out = pc_r;
        return_address_out        = aux_r;
        count_clear_out           = clr_r;
        drive_enable_out          = drv_r;
        foreign_insn_out          = foreign_r;
    end

    // ==========================================
    // Assertions
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (sys_rst_in);

    cond_taken_a: assert property (
        (insn_valid_in && kind == KIND_COND_REL
         && status_word(status_addr_in, core_control_status_a_in, core_control_status_b_in)
            [insn_word_in[8:5]] == insn_word_in[9])
        |=> pc_r == PC_W'(rel_target(16'($past(pc_r)), $past(insn_word_in[4:0]))))
        else $error("taken relative jump went to wrong target");

    offset_sign_a: assert property (
        (insn_valid_in && kind == KIND_CALL_REL && insn_word_in[4:0] == 5'h10)
        |=> pc_r == PC_W'($past(pc_r) - 5'h10))
        else $error("offset of -16 not applied");

    cond_fail_a: assert property (
        (insn_valid_in && kind == KIND_COND_REL && !br.cond_true)
        |=> pc_r == PC_W'($past(pc_r) + 1'b1) && $stable(aux_r) && $stable(drive_enable_out)
            && count_clear_out == 4'h0)
        else $error("failed test changed more than the counter");

    status_unmapped_a: assert property (
        (insn_valid_in && kind == KIND_COND_REL && !insn_word_in[9]
         && status_addr_in != 12'h101 && status_addr_in != 12'h102
         && status_addr_in != 12'h121 && status_addr_in != 12'h122)
        |=> pc_r != PC_W'($past(pc_r) + 1'b1) || $past(insn_word_in[4:0]) == 5'h01)
        else $error("unmapped status should read as zero");

    far_call_a: assert property (
        (insn_valid_in && kind == KIND_CALL_ABS)
        |=> pc_r == ($past(insn_word_in[3]) ? $past(jump_reg_two_in) : $past(jump_reg_one_in))
            && aux_r == $past(pc_r))
        else $error("absolute call target or return wrong");

    rel_call_a: assert property (
        (insn_valid_in && kind == KIND_CALL_REL)
        |=> aux_r == $past(pc_r)
            && pc_r == PC_W'(rel_target(16'($past(pc_r)), $past(insn_word_in[4:0]))))
        else $error("relative call target or return wrong");

    count_clear_a: assert property (
        (insn_valid_in && kind == KIND_TC_LOAD)
        |=> count_clear_out == ($past(insn_word_in[12]) ? 4'(1 << $past(insn_word_in[7:6])) : 4'h0)
            ##1 count_clear_out == 4'h0 || $past(insn_valid_in))
        else $error("counter clear pulse wrong");

    tc_write_a: assert property (
        (insn_valid_in && kind == KIND_TC_LOAD && tc_rd_sel_in == insn_word_in[7:6])
        ##1 (tc_rd_sel_in == $past(insn_word_in[7:6]) && !(insn_valid_in && kind == KIND_TC_LOAD))
        |=> tc_rd_data_out == $past(src_val, 2))
        else $error("terminal count not loaded from source register");

    shortcut_on_a: assert property (
        (insn_valid_in && kind == KIND_TC_LOAD && insn_word_in[11:10] == 2'h2 && insn_word_in[9:8] == 2'h0)
        |=> (drive_enable_out & $past(first_output_shortcut_in)) == $past(first_output_shortcut_in)
            && (drive_enable_out & ~$past(first_output_shortcut_in))
               == ($past(drive_enable_out) & ~$past(first_output_shortcut_in)))
        else $error("enable shortcut not applied to its outputs only");

    shortcut_keep_a: assert property (
        (insn_valid_in && kind == KIND_TC_LOAD && insn_word_in[11:8] == 4'h0)
        |=> $stable(drive_enable_out))
        else $error("keep shortcut changed outputs");

    shortcut_toggle_a: assert property (
        (insn_valid_in && kind == KIND_TC_LOAD && insn_word_in[11:10] == 2'h0 && insn_word_in[9:8] == 2'h3)
        |=> drive_enable_out == ($past(drive_enable_out) ^ $past(second_output_shortcut_in)))
        else $error("invert shortcut wrong");

endmodule : microcore_branch_counter_load

// [testbench/code_ram_model.sv]
module code_ram_model #(
    parameter int AW = 10
) (
    input  wire logic          clk_in,
    input  wire logic          run_in,
    input  wire logic          wr_en_in,
    input  wire logic [AW-1:0] wr_addr_in,
    input  wire logic [15:0]   wr_data_in,
    input  wire logic [AW-1:0] pc_in,
    output logic               valid_out,
    output logic      [15:0]   word_out
);
    timeunit 1ns;
    timeprecision 1ns;

    // ==========================================
    // Program store
    logic [15:0] mem_r [2**AW];
    logic        flip_r = 1'b0;

    always_ff @(posedge clk_in)
    begin
        flip_r <= ~flip_r;
        if (wr_en_in)
        begin
            mem_r[wr_addr_in] <= wr_data_in;
        end
    end

    // Idle word keeps changing so a stale fetch never looks valid
    assign valid_out = run_in;
    assign word_out  = run_in ? mem_r[pc_in] : (flip_r ? 16'h5a5a : 16'ha5a5);
endmodule : code_ram_model

// [testbench/tb.sv]
module tb;
    timeunit 1ns;
    timeprecision 1ns;

    // ==========================================
    // Signals
    localparam int PW = 10;
    localparam int DW = 16;
    localparam int OW = 12;
    logic            clk_in;
    logic            sys_rst_in;
    logic            run;
    logic            wr_en;
    logic [PW-1:0]   wr_addr;
    logic [15:0]     wr_data;
    logic            valid;
    logic [15:0]     word;
    logic [11:0]     st_addr;
    logic [31:0]     st_a;
    logic [31:0]     st_b;
    logic [PW-1:0]   jr1;
    logic [PW-1:0]   jr2;
    logic [8*DW-1:0] arith;
    logic [OW-1:0]   m1;
    logic [OW-1:0]   m2;
    logic [1:0]      tc_sel;
    logic [PW-1:0]   pc;
    logic [PW-1:0]   ret;
    logic [3:0]      clr;
    logic [OW-1:0]   drv;
    logic            fgn;
    logic [DW-1:0]   tc_data;
    logic [PW-1:0]   exp_pc;
    logic [PW-1:0]   exp_ret;
    logic [OW-1:0]   exp_drv;
    int              n_mismatch;
    int              num_checks;
    int              cyc;

    microcore_branch_counter_load #(.PC_W(PW), .DATA_W(DW), .OUT_W(OW)) microcore_branch_counter_load_inst (
        .clk_in                    (clk_in),
        .sys_rst_in                (sys_rst_in),
        .insn_valid_in             (valid),
        .insn_word_in              (word),
        .status_addr_in            (st_addr),
        .core_control_status_a_in  (st_a),
        .core_control_status_b_in  (st_b),
        .jump_reg_one_in           (jr1),
        .jump_reg_two_in           (jr2),
        .arith_regs_in             (arith),
        .first_output_shortcut_in  (m1),
        .second_output_shortcut_in (m2),
        .tc_rd_sel_in              (tc_sel),
        .micro_program_counter_out (pc),
        .return_address_out        (ret),
        .count_clear_out           (clr),
        .drive_enable_out          (drv),
        .foreign_insn_out          (fgn),
        .tc_rd_data_out            (tc_data)
    );

    code_ram_model #(.AW(PW)) code_ram_model_inst (
        .clk_in     (clk_in),
        .run_in     (run),
        .wr_en_in   (wr_en),
        .wr_addr_in (wr_addr),
        .wr_data_in (wr_data),
        .pc_in      (pc),
        .valid_out  (valid),
        .word_out   (word)
    );

    // ==========================================
    // Helpers
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Store one word at the tracked pc, then fetch it for exactly one edge
    task automatic exec(input logic [15:0] w);
        @(posedge clk_in);
        wr_en   <= 1'b1;
        wr_addr <= exp_pc;
        wr_data <= w;
        @(posedge clk_in);
        wr_en <= 1'b0;
        run   <= 1'b1;
        @(posedge clk_in);
        run <= 1'b0;
        @(negedge clk_in);
    endtask : exec

    function automatic logic [OW-1:0] sc(input logic [OW-1:0] d, input logic [OW-1:0] m, input logic [1:0] c);
        case (c)
            2'h0: return d;
            2'h1: return d & ~m;
            2'h2: return d | m;
            default: return d ^ m;
        endcase
    endfunction : sc

    // ==========================================
    // Scenarios
    task automatic t_cond_jump();
        logic [15:0] st;
        logic [4:0]  d;
        st = 16'hc35a;
        @(posedge clk_in);
        st_addr <= 12'h101;
        st_a    <= {16'h0000, st};
        for (int s = 0; s < 16; s++)
        begin
            for (int p = 0; p < 2; p++)
            begin
                d = 5'(s * 2 + p);
                exec({6'b001100, 1'(p), 4'(s), d});
                exp_pc = (st[s] == 1'(p)) ? exp_pc + PW'($signed(d)) : exp_pc + 1'b1;
                chk("cond jump pc", 16'(exp_pc), 16'(pc));
                chk("cond jump ret", 16'(exp_ret), 16'(ret));
            end
        end
    endtask : t_cond_jump

    task automatic t_status_src();
        logic [11:0] adr [5] = '{12'h101, 12'h102, 12'h121, 12'h122, 12'h100};
        @(posedge clk_in);
        st_a <= {16'h0004, 16'h0002};
        st_b <= {16'h0010, 16'h0008};
        for (int a = 0; a < 5; a++)
        begin
            @(posedge clk_in);
            st_addr <= adr[a];
            for (int s = 1; s < 5; s++)
            begin
                exec({6'b001100, 1'b1, 4'(s), 5'h03});
                exp_pc = (s == a + 1) ? exp_pc + 2'h3 : exp_pc + 1'b1;
                chk("status source", 16'(exp_pc), 16'(pc));
            end
        end
        // Unmapped address reads as zero, so a low-polarity test is taken
        exec({6'b001100, 1'b0, 4'h1, 5'h03});
        exp_pc = exp_pc + 2'h3;
        chk("unmapped status", 16'(exp_pc), 16'(pc));
    endtask : t_status_src

    task automatic t_calls();
        @(posedge clk_in);
        jr1 <= 10'h155;
        jr2 <= 10'h2aa;
        exec(16'h39b5);
        exp_ret = exp_pc;
        exp_pc  = 10'h155;
        chk("abs call one pc", 16'(exp_pc), 16'(pc));
        chk("abs call one ret", 16'(exp_ret), 16'(ret));
        exec(16'h39bd);
        exp_ret = exp_pc;
        exp_pc  = 10'h2aa;
        chk("abs call two pc", 16'(exp_pc), 16'(pc));
        chk("abs call two ret", 16'(exp_ret), 16'(ret));
        for (int i = 0; i < 2; i++)
        begin
            exec({11'h179, i ? 5'h0f : 5'h10});
            exp_ret = exp_pc;
            exp_pc  = i ? exp_pc + 4'hf : exp_pc - 5'h10;
            chk("rel call pc", 16'(exp_pc), 16'(pc));
            chk("rel call ret", 16'(exp_ret), 16'(ret));
        end
    endtask : t_calls

    task automatic t_load();
        for (int t = 0; t < 4; t++)
        begin
            for (int c = 0; c < 2; c++)
            begin
                @(posedge clk_in);
                tc_sel <= 2'(t);
                exec({3'b101, 1'(c), 4'h0, 2'(t), 3'(t * 2 + c), 3'b100});
                exp_pc = exp_pc + 1'b1;
                chk("load pc", 16'(exp_pc), 16'(pc));
                chk("clear pulse", 16'(c << t), 16'(clr));
                @(negedge clk_in);
                chk("clear end", 16'h0000, 16'(clr));
                chk("tc value", 16'(16'h1111 * (t * 2 + c + 1)), tc_data);
            end
        end
        // Later loads must not disturb the other counters
        for (int t = 0; t < 4; t++)
        begin
            @(posedge clk_in);
            tc_sel <= 2'(t);
            @(negedge clk_in);
            @(negedge clk_in);
            chk("tc select", 16'(16'h1111 * (t * 2 + 2)), tc_data);
        end
    endtask : t_load

    task automatic t_shortcuts();
        @(posedge clk_in);
        m1 <= 12'h03c;
        m2 <= 12'h0f0;
        for (int a = 0; a < 4; a++)
        begin
            for (int b = 0; b < 4; b++)
            begin
                exec({3'b101, 1'b0, 2'(a), 2'(b), 2'h0, 3'h0, 3'b100});
                exp_pc  = exp_pc + 1'b1;
                exp_drv = sc(sc(exp_drv, 12'h03c, 2'(a)), 12'h0f0, 2'(b));
                chk("drive", 16'(exp_drv), 16'(drv));
            end
        end
    endtask : t_shortcuts

    task automatic t_foreign();
        exec(16'h0000);
        exp_pc = exp_pc + 1'b1;
        chk("foreign pc", 16'(exp_pc), 16'(pc));
        chk("foreign pulse", 16'h0001, 16'(fgn));
        @(negedge clk_in);
        chk("foreign end", 16'h0000, 16'(fgn));
        chk("hold pc", 16'(exp_pc), 16'(pc));
    endtask : t_foreign

    // ==========================================
    // Run control
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test

    initial
    begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end

    // Whole run is well under a thousand cycles
    always @(posedge clk_in)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_mismatch++;
            stop_test();
        end
    end

    initial
    begin
        sys_rst_in = 1'b1;
        run = 1'b0;
        wr_en = 1'b0;
        wr_addr = '0;
        wr_data = '0;
        st_addr = 12'h101;
        st_a = '0;
        st_b = '0;
        jr1 = '0;
        jr2 = '0;
        m1 = '0;
        m2 = '0;
        tc_sel = '0;
        exp_pc = '0;
        exp_ret = '0;
        exp_drv = '0;
        for (int k = 0; k < 8; k++)
            arith[k*DW +: DW] = 16'(16'h1111 * (k + 1));
        repeat (2) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        @(negedge clk_in);
        chk("reset pc", 16'h0000, 16'(pc));
        chk("reset drive", 16'h0000, 16'(drv));
        chk("reset tc", 16'h0000, tc_data);
        t_cond_jump();
        t_status_src();
        t_calls();
        t_load();
        t_shortcuts();
        t_foreign();
        stop_test();
    end
endmodule : tb
